//--- rtl/ecm_apb.sv
// APB slave front end: decode, strobes and registered answer
`timescale 1ns/1ps
module ecm_apb
   import ecm_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   ecm_reg_if.apb regs
);

   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic setup;
   logic access;
   ecm_sel_t sel;

   // Map page and register index onto a register select
   function automatic ecm_sel_t decode(input logic [ADDR_W-1:0] a);
      logic [1:0] page;
      logic [4:0] idx;
      page = a[PAGE_LSB +: 2];
      idx = a[IDX_LSB +: 5];
      decode = SEL_NONE;
      if (a[ADDR_W-1:PAGE_LSB+2] == '0) begin
         if (page == PAGE_MON && idx == IDX_LVL_LO) decode = SEL_LVL_LO;
         if (page == PAGE_MON && idx == IDX_LVL_HI) decode = SEL_LVL_HI;
         if (page == PAGE_MON && idx == IDX_RES_LO) decode = SEL_RES_LO;
         if (page == PAGE_MON && idx == IDX_RES_HI) decode = SEL_RES_HI;
         if (page == PAGE_NOISE && idx == IDX_RATE_LO) decode = SEL_RATE_LO;
         if (page == PAGE_NOISE && idx == IDX_RATE_HI) decode = SEL_RATE_HI;
      end
   endfunction : decode

   // Phase decode and strobes toward the core
   assign sel = decode(paddr);
   assign setup = psel && !penable;
   assign access = psel && penable && pready_r;
   assign regs.sel = sel;
   assign regs.canc = paddr[CANC_BIT];
   assign regs.wdata = pwdata[7:0];
   assign regs.wr_stb = access && pwrite && (sel != SEL_NONE);
   assign regs.rd_stb = setup && !pwrite && (sel != SEL_NONE);

   // Answer is prepared in setup and presented in the first access cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && (sel == SEL_NONE);
         if (setup) begin
            prdata_r <= pwrite ? 32'h00000000 : {24'h000000, regs.rdata};
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule : ecm_apb

//--- rtl/ecm_pkg.sv
// Constants, types and notes for the echo canceller monitor registers
// Functional notes
// - Cancellation level is 16-bit two's complement; default means 0 dB.
// - Level falls as cancellation proceeds, never below the floor limit.
// - Path change, canceller reset or bypass return level to default.
// - Level drives low-level double-talk flag and fast/slow convergence.
// - Level bits 15..8 read and written at page 1 offset 05.
// - Residual after filter, before nonlinear processor, read as byte pair.
// - Smaller ramp rate setting gives faster noise estimator ramping.
// - Noise estimator ramp rate powers up at four.
package ecm_pkg;

   // Two cancellers share one register page layout
   localparam int NUM_CANC = 2;

   // Word index layout: page in [7:6], canceller in [5], register in [4:0]
   localparam logic [1:0] PAGE_MON = 2'h1;
   localparam logic [1:0] PAGE_NOISE = 2'h2;
   localparam logic [4:0] IDX_LVL_LO = 5'h04;
   localparam logic [4:0] IDX_LVL_HI = 5'h05;
   localparam logic [4:0] IDX_RES_LO = 5'h06;
   localparam logic [4:0] IDX_RES_HI = 5'h07;
   localparam logic [4:0] IDX_RATE_LO = 5'h16;
   localparam logic [4:0] IDX_RATE_HI = 5'h17;

   // Byte address bit fields of paddr
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int CANC_BIT = 7;
   localparam int PAGE_LSB = 8;

   // Values after reset, level decay step and fast convergence threshold
   localparam logic [15:0] LVL_RST = 16'h4800;
   localparam logic [15:0] RATE_RST = 16'h0004;
   localparam logic [15:0] LVL_STEP = 16'h0001;
   localparam logic [15:0] FAST_LEVEL_DEF = 16'h2400;

   // Register selected by a bus access
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_LVL_LO,
      SEL_LVL_HI,
      SEL_RES_LO,
      SEL_RES_HI,
      SEL_RATE_LO,
      SEL_RATE_HI
   } ecm_sel_t;

endpackage : ecm_pkg

//--- rtl/ecm_reg_if.sv
// Register access carrier between the bus slave and the canceller core
`timescale 1ns/1ps
interface ecm_reg_if;
   import ecm_pkg::*;
   logic wr_stb;
   logic rd_stb;
   logic canc;
   ecm_sel_t sel;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport apb (output wr_stb, output rd_stb, output canc, output sel,
      output wdata, input rdata);
   modport core (input wr_stb, input rd_stb, input canc, input sel,
      input wdata, output rdata);
endinterface : ecm_reg_if

//--- rtl/ecm_regs.sv
// Monitor and tuning registers for the canceller pair, with APB access
`timescale 1ns/1ps
module ecm_regs
   import ecm_pkg::*;
#(
   parameter logic [15:0] FAST_LEVEL = FAST_LEVEL_DEF
)
(
   input wire logic clock,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Canceller core side, index 0 is canceller A, 1 is canceller B
   input wire logic [NUM_CANC-1:0] sample_en,
   input wire logic [NUM_CANC-1:0][15:0] residual_in,
   input wire logic [NUM_CANC-1:0][15:0] cancellation_floor_limit,
   input wire logic [NUM_CANC-1:0] path_change,
   input wire logic [NUM_CANC-1:0] canc_reset,
   input wire logic [NUM_CANC-1:0] bypass,
   output logic [NUM_CANC-1:0] low_double_talk,
   output logic [NUM_CANC-1:0] fast_converge,
   output logic [NUM_CANC-1:0] noise_ramp_tick,
   output logic [NUM_CANC-1:0][15:0] cancellation_level
);

   ecm_reg_if regs ();

   // Per canceller read bytes, one selected onto the bus read data below
   logic [NUM_CANC-1:0][7:0] rbyte;

   // Bus slave front end
   ecm_apb u_apb (
      .clock(clock),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .regs(regs)
   );

   // Read data of the canceller that the address selects
   assign regs.rdata = rbyte[regs.canc];

   // Magnitude of a two's complement sample, most negative value saturated
   function automatic logic [15:0] mag16(input logic [15:0] v);
      logic [15:0] neg;
      neg = 16'(~v + 16'h0001);
      if (!v[15]) begin
         mag16 = v;
      end else if (v == 16'h8000) begin
         mag16 = 16'h7FFF;
      end else begin
         mag16 = neg;
      end
   endfunction : mag16

   // Signed greater-than of two 16-bit two's complement values
   function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
      sgt = $signed(a) > $signed(b);
   endfunction : sgt

   genvar c;
   generate
      for (c = 0; c < NUM_CANC; c = c + 1) begin : g_canc

         // Registers of this canceller
         logic [15:0] level_r;
         logic [15:0] level_nxt;
         logic [15:0] resid_r;
         logic [7:0] resid_hi_r;
         logic [15:0] rate_r;
         logic [15:0] rate_nxt;
         logic [15:0] ramp_cnt_r;
         logic [15:0] ramp_cnt_nxt;
         logic low_dt_r;
         logic fast_r;
         logic tick_r;

         // Decoded events
         logic mine;
         logic wr_lvl_lo;
         logic wr_lvl_hi;
         logic wr_rate_lo;
         logic wr_rate_hi;
         logic rd_res_lo;
         logic restart;
         logic [15:0] err_mag;
         logic quieter;
         logic louder;
         logic above_floor;
         logic below_floor;
         logic [15:0] level_dec;
         logic ramp_due;

         // Bus strobes that address this canceller
         assign mine = (regs.canc == c[0]);
         assign wr_lvl_lo = regs.wr_stb && mine && regs.sel == SEL_LVL_LO;
         assign wr_lvl_hi = regs.wr_stb && mine && regs.sel == SEL_LVL_HI;
         assign wr_rate_lo = regs.wr_stb && mine && regs.sel == SEL_RATE_LO;
         assign wr_rate_hi = regs.wr_stb && mine && regs.sel == SEL_RATE_HI;
         assign rd_res_lo = regs.rd_stb && mine && regs.sel == SEL_RES_LO;

         // Any event that restarts the estimate
         assign restart = path_change[c] || canc_reset[c] || bypass[c];

         // Compare residual magnitude against the current estimate
         assign err_mag = mag16(residual_in[c]);
         assign quieter = sample_en[c] && sgt(level_r, err_mag);
         assign louder = sgt(err_mag, level_r);
         assign above_floor = sgt(level_r, cancellation_floor_limit[c]);
         assign below_floor = sgt(cancellation_floor_limit[c], level_r);
         assign level_dec = 16'(level_r - LVL_STEP);

         // Level: restart first, then decay or floor clamp, then software
         always_comb begin
            level_nxt = level_r;
            if (wr_lvl_lo) begin
               level_nxt[7:0] = regs.wdata;
            end
            if (wr_lvl_hi) begin
               level_nxt[15:8] = regs.wdata;
            end
            if (quieter && above_floor) begin
               level_nxt = level_dec;
            end else if (below_floor) begin
               level_nxt = cancellation_floor_limit[c];
            end
            if (restart) begin
               level_nxt = LVL_RST;
            end
         end

         // Estimate register, 0 dB after reset
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               level_r <= LVL_RST;
            end else begin
               level_r <= level_nxt;
            end
         end

         // Residual capture; reading the low byte freezes the high byte
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               resid_r <= 16'h0000;
               resid_hi_r <= 8'h00;
            end else begin
               if (sample_en[c]) begin
                  resid_r <= residual_in[c];
               end
               if (rd_res_lo) begin
                  resid_hi_r <= resid_r[15:8];
               end
            end
         end

         // Ramp rate setting, byte writable
         always_comb begin
            rate_nxt = rate_r;
            if (wr_rate_lo) begin
               rate_nxt[7:0] = regs.wdata;
            end
            if (wr_rate_hi) begin
               rate_nxt[15:8] = regs.wdata;
            end
         end

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               rate_r <= RATE_RST;
            end else begin
               rate_r <= rate_nxt;
            end
         end

         // Ramp divider: one tick every rate+1 samples
         assign ramp_due = sample_en[c] && (ramp_cnt_r >= rate_r);

         always_comb begin
            ramp_cnt_nxt = ramp_cnt_r;
            if (restart || ramp_due) begin
               ramp_cnt_nxt = 16'h0000;
            end else if (sample_en[c]) begin
               ramp_cnt_nxt = 16'(ramp_cnt_r + 16'h0001);
            end
         end

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               ramp_cnt_r <= 16'h0000;
               tick_r <= 1'b0;
            end else begin
               ramp_cnt_r <= ramp_cnt_nxt;
               tick_r <= ramp_due && !restart;
            end
         end

         // Double-talk and convergence speed from the estimate
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               low_dt_r <= 1'b0;
               fast_r <= 1'b1;
            end else begin
               if (restart) begin
                  low_dt_r <= 1'b0;
               end else if (sample_en[c]) begin
                  low_dt_r <= louder;
               end
               fast_r <= sgt(level_r, FAST_LEVEL);
            end
         end

         // Byte returned for a read of this canceller
         always_comb begin
            case (regs.sel)
               SEL_LVL_LO: rbyte[c] = level_r[7:0];
               SEL_LVL_HI: rbyte[c] = level_r[15:8];
               SEL_RES_LO: rbyte[c] = resid_r[7:0];
               SEL_RES_HI: rbyte[c] = resid_hi_r;
               SEL_RATE_LO: rbyte[c] = rate_r[7:0];
               SEL_RATE_HI: rbyte[c] = rate_r[15:8];
               default: rbyte[c] = 8'h00;
            endcase
         end

         // Outputs straight from the registers above
         assign low_double_talk[c] = low_dt_r;
         assign fast_converge[c] = fast_r;
         assign noise_ramp_tick[c] = tick_r;
         assign cancellation_level[c] = level_r;

      end
   endgenerate

endmodule : ecm_regs

//--- sim/ecm_regs_sva.sv
// Concurrent checks on the monitor register block ports
`timescale 1ns/1ps
module ecm_regs_sva
   import ecm_pkg::*;
#(
   parameter logic [15:0] FAST_LEVEL = FAST_LEVEL_DEF
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_CANC-1:0] sample_en,
   input wire logic [NUM_CANC-1:0][15:0] residual_in,
   input wire logic [NUM_CANC-1:0][15:0] cancellation_floor_limit,
   input wire logic [NUM_CANC-1:0] path_change,
   input wire logic [NUM_CANC-1:0] canc_reset,
   input wire logic [NUM_CANC-1:0] bypass,
   input wire logic [NUM_CANC-1:0] low_double_talk,
   input wire logic [NUM_CANC-1:0] fast_converge,
   input wire logic [NUM_CANC-1:0] noise_ramp_tick,
   input wire logic [NUM_CANC-1:0][15:0] cancellation_level
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Restart request of each canceller, level and floor of canceller A
   wire logic rs0 = path_change[0] | canc_reset[0] | bypass[0];
   wire logic rs1 = path_change[1] | canc_reset[1] | bypass[1];
   wire logic [15:0] lvl0 = cancellation_level[0];
   wire logic [15:0] flr0 = cancellation_floor_limit[0];
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd_hi;
      s_setup ##0 (!pwrite && paddr == 12'h114);
   endsequence
   property p_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("late or long ready");
   property p_unmapped;
      s_setup ##0 (!pwrite && paddr[11:10] != 2'h0) |=>
         pready && pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   property p_lvl_hi;
      s_rd_hi |=> prdata == {24'h0, $past(lvl0[15:8])};
   endproperty
   a_lvl_hi: assert property (p_lvl_hi) else $error("level byte wrong");
   property p_decay;
      sample_en[0] && !rs0 && residual_in[0] == 16'h0 && $signed(lvl0) > 0
         && $signed(lvl0) > $signed(flr0) |=> lvl0 == $past(lvl0) - LVL_STEP;
   endproperty
   a_decay: assert property (p_decay) else $error("level did not decay");
   property p_floor;
      sample_en[0] && !rs0 |=> $signed(lvl0) >= $signed($past(flr0));
   endproperty
   a_floor: assert property (p_floor) else $error("level under floor");
   property p_restart;
      rs0 |=> lvl0 == LVL_RST && !low_double_talk[0] && !noise_ramp_tick[0];
   endproperty
   a_restart: assert property (p_restart) else $error("A not restarted");
   property p_restart_b;
      rs1 |=> cancellation_level[1] == LVL_RST;
   endproperty
   a_restart_b: assert property (p_restart_b) else $error("B no reset");
   property p_fast;
      1'b1 |=> fast_converge[0] ==
         ($signed($past(lvl0)) > $signed(FAST_LEVEL));
   endproperty
   a_fast: assert property (p_fast) else $error("speed select wrong");
   property p_dtalk;
      sample_en[0] && !rs0 && !lvl0[15] && lvl0 != 16'h7FFF &&
         (residual_in[0] == 16'h0 || residual_in[0] == 16'h7FFF) |=>
         low_double_talk[0] == ($past(residual_in[0]) == 16'h7FFF);
   endproperty
   a_dtalk: assert property (p_dtalk) else $error("double talk wrong");
   property p_tick;
      noise_ramp_tick[0] |-> $past(sample_en[0]) && !$past(rs0);
   endproperty
   a_tick: assert property (p_tick) else $error("tick without sample");
endmodule : ecm_regs_sva

bind ecm_regs ecm_regs_sva #(.FAST_LEVEL(FAST_LEVEL)) u_sva (.clock(clock),
   .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sample_en(sample_en), .residual_in(residual_in),
   .cancellation_floor_limit(cancellation_floor_limit),
   .path_change(path_change), .canc_reset(canc_reset), .bypass(bypass),
   .low_double_talk(low_double_talk), .fast_converge(fast_converge),
   .noise_ramp_tick(noise_ramp_tick),
   .cancellation_level(cancellation_level));

//--- sim/ecm_regs_tb_top.sv
// Directed register and core side test of the monitor register block
`timescale 1ns/1ps
module ecm_regs_tb_top
   import ecm_pkg::*;
;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] rd;
   logic [NUM_CANC-1:0] sample_en, path_change, canc_reset, bypass;
   logic [NUM_CANC-1:0] low_double_talk, fast_converge, noise_ramp_tick;
   logic [NUM_CANC-1:0][15:0] residual_in, floor_lim, cancellation_level;
   int num_errors, n_tests, n_ticks, n_ticks_b;
   ecm_regs dut (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_en(sample_en), .residual_in(residual_in),
      .cancellation_floor_limit(floor_lim), .path_change(path_change),
      .canc_reset(canc_reset), .bypass(bypass),
      .low_double_talk(low_double_talk), .fast_converge(fast_converge),
      .noise_ramp_tick(noise_ramp_tick),
      .cancellation_level(cancellation_level));
   // Free running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Counts ramp ticks of canceller A and of canceller B
   always @(posedge clock) begin
      if (noise_ramp_tick[0] === 1'b1) n_ticks++;
      if (noise_ramp_tick[1] === 1'b1) n_ticks_b++;
   end
   task automatic give_verdict;
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_flag
   // Byte address of a register
   function automatic logic [11:0] ra(input int c, input logic [1:0] pg,
      input logic [4:0] ix);
      return {2'h0, pg, c[0], ix, 2'h0};
   endfunction : ra
   // One APB transfer; read byte and error land in rd and er
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] wd);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clock);
      end
      if (k >= 20) begin
         num_errors++;
         give_verdict();
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk_val({8'h0, rd}, {8'h0, exp});
   endtask : rdc
   // Consecutive residual samples on one canceller
   task automatic samp(input int c, input logic [15:0] r, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         sample_en[c] <= 1'b1;
         residual_in[c] <= r;
      end
      @(posedge clock);
      sample_en[c] <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : samp
   // One cycle restart of both cancellers by path change, reset or bypass
   task automatic restart(input int k);
      @(posedge clock);
      if (k == 0) path_change <= 2'h3;
      else if (k == 1) canc_reset <= 2'h3;
      else bypass <= 2'h3;
      @(posedge clock);
      path_change <= 2'h0;
      canc_reset <= 2'h0;
      bypass <= 2'h0;
      repeat (2) @(posedge clock);
   endtask : restart
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sample_en, path_change, canc_reset, bypass, residual_in} = '0;
      floor_lim = {2{16'h8000}};
      num_errors = 0;
      n_tests = 0;
      n_ticks_b = 0;
      reset_n = 1'b0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      for (int c = 0; c < NUM_CANC; c++) begin
         rdc(ra(c, PAGE_MON, IDX_LVL_LO), 8'h00);
         rdc(ra(c, PAGE_MON, IDX_LVL_HI), 8'h48);
         rdc(ra(c, PAGE_NOISE, IDX_RATE_LO), 8'h04);
         rdc(ra(c, PAGE_NOISE, IDX_RATE_HI), 8'h00);
      end
      apb(1'b0, 12'h400, 8'h00);
      chk_flag(er, 1'b1);
      apb(1'b1, ra(0, PAGE_MON, IDX_RES_LO), 8'hFF);
      chk_flag(er, 1'b0);
      apb(1'b1, ra(0, PAGE_MON, IDX_LVL_HI), 8'h30);
      apb(1'b1, ra(0, PAGE_MON, IDX_LVL_LO), 8'h10);
      rdc(ra(0, PAGE_MON, IDX_LVL_HI), 8'h30);
      chk_val(cancellation_level[0], 16'h3010);
      floor_lim[0] <= 16'h3008;
      samp(0, 16'h0000, 10);
      chk_val(cancellation_level[0], 16'h3008);
      rdc(ra(0, PAGE_MON, IDX_LVL_LO), 8'h08);
      floor_lim[0] <= 16'h3100;
      samp(0, 16'h0000, 1);
      chk_val(cancellation_level[0], 16'h3100);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, ra(0, PAGE_MON, IDX_LVL_HI), 8'h30);
         apb(1'b1, ra(1, PAGE_MON, IDX_LVL_HI), 8'h30);
         restart(k);
         chk_val(cancellation_level[0], LVL_RST);
         chk_val(cancellation_level[1], LVL_RST);
      end
      floor_lim[0] <= 16'h8000;
      chk_flag(fast_converge[0], 1'b1);
      apb(1'b1, ra(0, PAGE_MON, IDX_LVL_HI), 8'h10);
      repeat (3) @(posedge clock);
      chk_flag(fast_converge[0], 1'b0);
      samp(0, 16'h7FFF, 1);
      chk_flag(low_double_talk[0], 1'b1);
      samp(0, 16'h0000, 1);
      chk_flag(low_double_talk[0], 1'b0);
      chk_val(cancellation_level[0], 16'h0FFF);
      samp(1, 16'hA5C3, 1);
      chk_flag(low_double_talk[1], 1'b1);
      chk_flag(fast_converge[1], 1'b1);
      rdc(ra(1, PAGE_MON, IDX_RES_LO), 8'hC3);
      samp(1, 16'h1234, 1);
      chk_flag(low_double_talk[1], 1'b0);
      rdc(ra(1, PAGE_MON, IDX_RES_HI), 8'hA5);
      rdc(ra(1, PAGE_MON, IDX_RES_LO), 8'h34);
      rdc(ra(1, PAGE_MON, IDX_RES_HI), 8'h12);
      restart(1);
      n_ticks = 0;
      samp(0, 16'h0000, 20);
      chk_val(n_ticks[15:0], 16'd4);
      apb(1'b1, ra(0, PAGE_NOISE, IDX_RATE_LO), 8'h01);
      restart(1);
      n_ticks = 0;
      samp(0, 16'h0000, 20);
      chk_val(n_ticks[15:0], 16'd10);
      samp(1, 16'h0000, 5);
      chk_val(n_ticks_b[15:0], 16'd1);
      give_verdict();
   end
endmodule : ecm_regs_tb_top
